// file: core/usb_device_port_interrupt_regs.sv
// Interrupt enable, mask, status and clear registers of a full-speed USB device port.
//
// Added by the designer: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// What this block does
// - A one written to an endpoint bit of the enable-set register enables that endpoint's interrupt, a zero does nothing.
// - A one written to bit 8, 9, 10, 11 or 13 of the enable-set register enables that bus event, a zero does nothing.
// - A one written to an endpoint bit of the enable-clear register disables that endpoint's interrupt.
// - A one written to a bus-event bit of the enable-clear register disables that event, at the same positions.
// - The enable view reads one for every enabled interrupt and zero for every disabled one.
// - Bit 12 of the enable view always reads one and no disable write touches it.
// - The resume enable bit comes out of reset set.
// - An endpoint pending bit is high while any of that endpoint's five flags is set.
// - An endpoint pending bit stays until its flags are cleared at the endpoint and ignores the pending clear register.
// - After three milliseconds without bus activity the suspend pending bit is set and the port enters suspend.
// - Resume signalling on the port sets the resume pending bit.
// - Every start-of-frame token sets the frame start pending bit.
// - The end of a bus reset sets pending bit 12 and makes endpoint 0 ready for enumeration.
// - The wakeup pending bit is set by resume or reset signalling since its last clear.
// - A one written to a bus-event bit of the pending clear register clears that pending bit, a zero does nothing.
module usb_device_port_interrupt_regs
  import usb_irq_pkg::*;
#(
  parameter logic [IDLE_COUNT_W-1:0] IDLE_CYCLES = IDLE_COUNT_W'(SUSPEND_IDLE_CYCLES)
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // Endpoint flags, one bit per endpoint
  input  wire logic [5:0]  setup_received_flag,
  input  wire logic [5:0]  rx_bank0_full_flag,
  input  wire logic [5:0]  rx_bank1_full_flag,
  input  wire logic [5:0]  tx_complete_flag,
  input  wire logic [5:0]  stall_acknowledged_flag,
  // Bus events from the serial interface engine
  input  wire logic        bus_activity,
  input  wire logic        resume_signalling,
  input  wire logic        frame_start_token,
  input  wire logic        bus_reset_active,
  // External resume pin
  input  wire logic        external_resume_pin,
  // Status to the processor and the port
  output logic             irq,
  output logic             suspended,
  output logic             endpoint0_ready
);

  typedef struct packed {
    logic [31:0] enable;
    logic [31:0] pending;
    logic [31:0] rdata;
    logic        wait_n;
    logic        wait_req;
    logic        irq;
    link_state_t link;
    logic        susp;
    logic        ep0_ready;
    logic        ext_sync1;
    logic        ext_sync2;
    logic        ext_prev;
    logic        resume_prev;
    logic        reset_prev;
  } regs_state_t;

  regs_state_t s_q;
  regs_state_t s_d;
  logic        idle_expired;

  // Expands the four byte enables to a 32-bit lane mask.
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // Rising edge of a level sampled in consecutive cycles.
  function automatic logic rose(input logic prev, input logic cur);
    rose = cur & ~prev;
  endfunction

  bus_idle_timer #(
    .IDLE_CYCLES (IDLE_CYCLES)
  ) u_idle (
    .clk_sys      (clk_sys),
    .rst_n        (rst_n),
    .bus_activity (bus_activity),
    .idle_expired (idle_expired)
  );

  always_comb begin
    logic [31:0] wmask;
    logic [31:0] enable_view;
    logic [31:0] set_bits;
    logic [31:0] clr_bits;
    logic [5:0]  ep_any;
    logic        commit;
    wmask       = '0;
    enable_view = '0;
    set_bits    = '0;
    clr_bits    = '0;
    ep_any      = '0;
    commit      = 1'b0;
    s_d         = s_q;

    // Synchroniser for the pin; only the second stage feeds logic.
    s_d.ext_sync1   = external_resume_pin;
    s_d.ext_sync2   = s_q.ext_sync1;
    s_d.ext_prev    = s_q.ext_sync2;
    s_d.resume_prev = resume_signalling;
    s_d.reset_prev  = bus_reset_active;

    enable_view = s_q.enable | UNMASKABLE_BITS;
    wmask       = writedata & lane_mask(byteenable);
    commit      = write & s_q.wait_n;

    // Bus slave: the first cycle of a request raises the answer, the next releases it.
    s_d.wait_n = (read | write) & ~s_q.wait_n;
    // Kept as its own flop so that waitrequest leaves the block straight from a register.
    s_d.wait_req = ~s_d.wait_n;
    if (read && !s_q.wait_n) begin
      case (address)
        OFS_IRQ_ENABLE_VIEW: begin
          s_d.rdata = enable_view;
        end
        OFS_IRQ_PENDING_VIEW: begin
          s_d.rdata = s_q.pending;
        end
        default: begin
          s_d.rdata = READ_ZERO;
        end
      endcase
    end

    // Enable set and clear take effect only where a one is written.
    if (commit && address == OFS_IRQ_ENABLE_SET) begin
      s_d.enable = s_q.enable | (wmask & ENABLE_WRITABLE);
    end
    if (commit && address == OFS_IRQ_ENABLE_CLEAR) begin
      s_d.enable = s_q.enable & ~(wmask & ENABLE_WRITABLE);
    end
    s_d.enable = s_d.enable | UNMASKABLE_BITS;

    // Suspend and leaving it.
    case (s_q.link)
      LINK_ACTIVE: begin
        if (idle_expired) begin
          s_d.link = LINK_SUSPENDED;
          set_bits[POS_SUSPEND_IRQ] = 1'b1;
        end
      end
      LINK_SUSPENDED: begin
        if (bus_activity || resume_signalling || bus_reset_active) begin
          s_d.link = LINK_ACTIVE;
        end
      end
      default: begin
        s_d.link = LINK_ACTIVE;
      end
    endcase
    s_d.susp = (s_d.link == LINK_SUSPENDED);

    set_bits[POS_RESUME_IRQ]          = rose(s_q.resume_prev, resume_signalling);
    set_bits[POS_EXTERNAL_RESUME_IRQ] = rose(s_q.ext_prev, s_q.ext_sync2);
    set_bits[POS_FRAME_START_IRQ]     = frame_start_token;
    set_bits[POS_BUS_RESET_DONE_IRQ]  = rose(bus_reset_active, s_q.reset_prev);
    set_bits[POS_WAKEUP_IRQ]          = rose(s_q.resume_prev, resume_signalling)
                                      | rose(s_q.reset_prev, bus_reset_active);

    // Endpoint 0 may take requests once the bus reset is over.
    if (bus_reset_active) begin
      s_d.ep0_ready = 1'b0;
    end else if (set_bits[POS_BUS_RESET_DONE_IRQ]) begin
      s_d.ep0_ready = 1'b1;
    end

    if (commit && address == OFS_IRQ_PENDING_CLR) begin
      clr_bits = wmask & PENDING_CLEARABLE;
    end

    // A new event in the cycle of its clear keeps the bit set.
    s_d.pending = (s_q.pending & ~clr_bits & PENDING_CLEARABLE) | (set_bits & PENDING_CLEARABLE);

    for (int i = 0; i < ENDPOINT_COUNT; i++) begin
      ep_any[i] = setup_received_flag[i] | rx_bank0_full_flag[i] | rx_bank1_full_flag[i]
                | tx_complete_flag[i] | stall_acknowledged_flag[i];
    end
    s_d.pending[ENDPOINT_COUNT-1:0] = ep_any;

    s_d.irq = |(s_d.pending & s_d.enable);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q             <= '0;
      s_q.enable      <= ENABLE_RESET;
      s_q.pending     <= PENDING_RESET;
      s_q.link        <= LINK_ACTIVE;
      s_q.wait_req    <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign readdata        = s_q.rdata;
  assign waitrequest     = s_q.wait_req;
  assign irq             = s_q.irq;
  assign suspended       = s_q.susp;
  assign endpoint0_ready = s_q.ep0_ready;

endmodule // usb_device_port_interrupt_regs

// file: pkg/usb_irq_pkg.sv
// Constants, register map and types shared by the USB device port interrupt logic.
package usb_irq_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFS_IRQ_ENABLE_SET   = 8'h10;
  localparam logic [7:0] OFS_IRQ_ENABLE_CLEAR = 8'h14;
  localparam logic [7:0] OFS_IRQ_ENABLE_VIEW  = 8'h18;
  localparam logic [7:0] OFS_IRQ_PENDING_VIEW = 8'h1C;
  localparam logic [7:0] OFS_IRQ_PENDING_CLR  = 8'h20;

  // Field positions shared by all five registers.
  localparam int ENDPOINT_COUNT          = 6;
  localparam int POS_SUSPEND_IRQ         = 8;
  localparam int POS_RESUME_IRQ          = 9;
  localparam int POS_EXTERNAL_RESUME_IRQ = 10;
  localparam int POS_FRAME_START_IRQ     = 11;
  localparam int POS_BUS_RESET_DONE_IRQ  = 12;
  localparam int POS_WAKEUP_IRQ          = 13;

  // Writable enable bits; bit 12 is absent because it cannot be masked.
  localparam logic [31:0] ENABLE_WRITABLE   = 32'h0000_2F3F;
  // Bus-event bits that the pending clear register reaches.
  localparam logic [31:0] PENDING_CLEARABLE = 32'h0000_3F00;
  // Bit 12 of the enable view is hard-wired to one.
  localparam logic [31:0] UNMASKABLE_BITS   = 32'h0000_1000;
  // Reset value of the enable state: resume enabled, bit 12 set.
  localparam logic [31:0] ENABLE_RESET      = 32'h0000_1200;
  localparam logic [31:0] PENDING_RESET     = 32'h0000_0000;
  localparam logic [31:0] READ_ZERO         = 32'h0000_0000;

  // Bus idle time before suspend.
  localparam int CLK_HZ          = 50_000_000;
  localparam int SUSPEND_IDLE_MS = 3;
  localparam int SUSPEND_IDLE_CYCLES = (CLK_HZ / 1000) * SUSPEND_IDLE_MS;
  localparam int IDLE_COUNT_W    = 18;

  typedef enum logic [0:0] {
    LINK_ACTIVE,
    LINK_SUSPENDED
  } link_state_t;

endpackage : usb_irq_pkg

// file: core/bus_idle_timer.sv
// Counts idle clock cycles on the USB bus and flags a suspend condition.
`timescale 1ns/1ps
module bus_idle_timer
  import usb_irq_pkg::*;
#(
  parameter logic [IDLE_COUNT_W-1:0] IDLE_CYCLES = IDLE_COUNT_W'(SUSPEND_IDLE_CYCLES)
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // Bus side
  input  wire logic bus_activity,
  // Result
  output logic      idle_expired
);

  typedef struct packed {
    logic [IDLE_COUNT_W-1:0] count;
    logic                    expired;
  } timer_state_t;

  timer_state_t s_q;
  timer_state_t s_d;

  // The count holds at the limit so that the expiry is reported once per idle period.
  always_comb begin
    s_d = s_q;
    s_d.expired = 1'b0;
    if (bus_activity) begin
      s_d.count = '0;
    end else if (s_q.count != IDLE_CYCLES) begin
      s_d.count = s_q.count + IDLE_COUNT_W'(1);
      s_d.expired = (s_q.count == IDLE_CYCLES - IDLE_COUNT_W'(1));
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign idle_expired = s_q.expired;

endmodule // bus_idle_timer

// file: tb/usb_irq_checker_sva.sv
// Port assertions for the USB device port interrupt registers.
`timescale 1ns/1ps
module usb_irq_checker
  import usb_irq_pkg::*;
#(parameter logic [IDLE_COUNT_W-1:0] IDLE_CYCLES = IDLE_COUNT_W'(SUSPEND_IDLE_CYCLES)) (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_n,
  // Register bus
  input wire logic [7:0]  address,
  input wire logic        read,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  // Endpoint flags
  input wire logic [5:0]  setup_received_flag,
  input wire logic [5:0]  rx_bank0_full_flag,
  input wire logic [5:0]  rx_bank1_full_flag,
  input wire logic [5:0]  tx_complete_flag,
  input wire logic [5:0]  stall_acknowledged_flag,
  // Bus and port status
  input wire logic        bus_activity,
  input wire logic        bus_reset_active,
  input wire logic        suspended,
  input wire logic        endpoint0_ready
);
  localparam int IDLE = int'(IDLE_CYCLES);
  logic [5:0] ep_or;
  logic       rd_view;
  logic       rd_pend;
  int         idle_q;
  assign ep_or = setup_received_flag | rx_bank0_full_flag | rx_bank1_full_flag | tx_complete_flag
               | stall_acknowledged_flag;
  assign rd_view = read && !waitrequest && address == OFS_IRQ_ENABLE_VIEW;
  assign rd_pend = read && !waitrequest && address == OFS_IRQ_PENDING_VIEW;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Idle cycles on the bus, saturating just past the suspend point.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      idle_q <= 0;
    else if (bus_activity)
      idle_q <= 0;
    else if (idle_q < IDLE + 3)
      idle_q <= idle_q + 1;
  end
  a_unmaskable_mask_bit_one: assert property (rd_view |-> readdata[12])
    else $error("enable view bit 12 low");
  a_view_unused_zero: assert property (rd_view |-> (readdata & ~32'h0000_3F3F) == 32'h0)
    else $error("enable view unused bits set");
  a_ep_pending: assert property (rd_pend && $stable(ep_or) && $past(ep_or) == $past(ep_or, 2)
    && $past(ep_or, 2) == $past(ep_or, 3) |-> readdata[5:0] == ep_or) else $error("endpoint pending wrong");
  a_suspend_early: assert property ($rose(suspended) |-> idle_q + 1 >= IDLE && idle_q <= IDLE + 1)
    else $error("suspend at wrong idle count");
  a_suspend_late: assert property (idle_q == IDLE + 2 |-> suspended)
    else $error("suspend missing");
  a_suspend_exit: assert property (suspended && bus_activity |=> !suspended)
    else $error("suspend kept after activity");
  a_reset_ends_ready: assert property ($fell(bus_reset_active) |-> ##[1:2] endpoint0_ready)
    else $error("endpoint 0 not ready after bus reset");
  a_reset_holds_off: assert property (bus_reset_active |=> !endpoint0_ready)
    else $error("endpoint 0 ready during bus reset");
endmodule // usb_irq_checker

// file: tb/usb_host_model.sv
// Behavioural USB host that drives bus events into the port.
`timescale 1ns/1ps
module usb_host_model (
  // Clock
  input wire logic clk_sys,
  // Bus events
  output logic     bus_activity,
  output logic     resume_signalling,
  output logic     frame_start_token,
  output logic     bus_reset_active
);
  initial {bus_activity, resume_signalling, frame_start_token, bus_reset_active} = 4'h8;
  // Event k for n cycles (frame start for one cycle only): 0 frame start, 1 resume, 2 bus reset, else idle bus.
  // Resume and reset signalling are bus traffic, so activity stays high then.
  task automatic event_go(input int k, input int n);
    @(posedge clk_sys);
    case (k)
      0: frame_start_token <= 1'b1;
      1: resume_signalling <= 1'b1;
      2: bus_reset_active <= 1'b1;
      default: bus_activity <= 1'b0;
    endcase
    repeat (k == 0 ? 1 : n) @(posedge clk_sys);
    {bus_activity, resume_signalling, frame_start_token, bus_reset_active} <= 4'h8;
  endtask
endmodule // usb_host_model

// file: tb/usb_device_port_interrupt_regs_tb_top.sv
// Self-checking bench for the USB device port interrupt registers.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module usb_device_port_interrupt_regs_tb_top
  import usb_irq_pkg::*;
;
  localparam int IDLE = 20;
  logic        clk_sys, rst_n, read, write, ext_pin, waitrequest, irq, ep0_ready;
  logic        act, rsm, sof, brst;
  logic [7:0]  address;
  logic [31:0] writedata, readdata, en_exp, rng, exp_rd;
  logic [3:0]  byteenable;
  logic [5:0]  flg [5];
  logic [31:0] rd_q [$];
  logic [31:0] ev_exp [5] = '{32'h0000_0800, 32'h0000_2200, 32'h0000_3000, 32'h0000_0100, 32'h0000_0400};
  int          n_errors, checked, j;
  usb_host_model u_host (.clk_sys(clk_sys), .bus_activity(act), .resume_signalling(rsm),
    .frame_start_token(sof), .bus_reset_active(brst));
  usb_device_port_interrupt_regs #(.IDLE_CYCLES(IDLE_COUNT_W'(IDLE))) u_dut (.clk_sys(clk_sys),
    .rst_n(rst_n), .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest), .setup_received_flag(flg[0]),
    .rx_bank0_full_flag(flg[1]), .rx_bank1_full_flag(flg[2]), .tx_complete_flag(flg[3]),
    .stall_acknowledged_flag(flg[4]), .bus_activity(act), .resume_signalling(rsm), .frame_start_token(sof),
    .bus_reset_active(brst), .external_resume_pin(ext_pin), .irq(irq), .suspended(), .endpoint0_ready(ep0_ready));
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  // One Avalon access; for a read, d is the expected data.
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    logic [31:0] be_mask;
    @(posedge clk_sys);
    address <= a;
    write <= w;
    read <= !w;
    writedata <= d;
    if (!w) rd_q.push_back(d);
    do @(posedge clk_sys); while (waitrequest !== 1'b0);
    write <= 1'b0;
    read <= 1'b0;
    // Disabled byte lanes write as zero, so they neither set nor clear.
    be_mask = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
    if (w && a == OFS_IRQ_ENABLE_SET) en_exp |= d & be_mask & ENABLE_WRITABLE;
    if (w && a == OFS_IRQ_ENABLE_CLEAR) en_exp &= ~(d & be_mask & ENABLE_WRITABLE);
  endtask
  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk_sys);
    `CHK("irq", e, irq)
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    if (read && waitrequest === 1'b0) begin
      exp_rd = rd_q.pop_front();
      `CHK("readdata", exp_rd, readdata)
    end
  end
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    results();
  end
  initial begin
    {rst_n, read, write, ext_pin} = 4'h0;
    {address, writedata, byteenable} = {8'h00, 32'h0, 4'hF};
    flg = '{default: 6'h00};
    rng = 32'h0000_BCF8;
    en_exp = ENABLE_RESET;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    bus(OFS_IRQ_ENABLE_VIEW, 1'b0, ENABLE_RESET);
    bus(OFS_IRQ_PENDING_CLR, 1'b1, 32'h0000_2200);
    bus(OFS_IRQ_PENDING_VIEW, 1'b0, 32'h0);
    irq_is(1'b0);
    bus(8'h24, 1'b0, 32'h0);
    bus(OFS_IRQ_ENABLE_VIEW, 1'b1, 32'h0);
    bus(OFS_IRQ_ENABLE_SET, 1'b0, 32'h0);
    for (int i = 0; i < 12; i++) begin
      byteenable <= (i == 11) ? 4'hF : 4'(xs());
      bus(i[0] ? OFS_IRQ_ENABLE_CLEAR : OFS_IRQ_ENABLE_SET, 1'b1, i == 11 ? 32'hFFFF_FFFF : xs());
      bus(OFS_IRQ_ENABLE_VIEW, 1'b0, en_exp | UNMASKABLE_BITS);
    end
    for (int k = 0; k < 5; k++) begin
      j = int'(xs() % 32'h6);
      flg[k][j] <= 1'b1;
      bus(OFS_IRQ_PENDING_CLR, 1'b1, 32'h0000_003F);
      bus(OFS_IRQ_PENDING_VIEW, 1'b0, 32'h1 << j);
      irq_is(1'b0);
      bus(OFS_IRQ_ENABLE_SET, 1'b1, 32'h1 << j);
      irq_is(1'b1);
      flg[k][j] <= 1'b0;
      bus(OFS_IRQ_PENDING_VIEW, 1'b0, 32'h0);
      irq_is(1'b0);
      bus(OFS_IRQ_ENABLE_CLEAR, 1'b1, 32'h1 << j);
    end
    for (int p = 0; p < 2; p++) begin
      bus(p ? OFS_IRQ_ENABLE_SET : OFS_IRQ_ENABLE_CLEAR, 1'b1, 32'hFFFF_FFFF);
      for (int k = 0; k < 5; k++) begin
        if (k == 4) ext_pin <= 1'b1;
        else u_host.event_go(k, k == 3 ? IDLE + 4 : 2 + p * 6);
        repeat (6) @(posedge clk_sys);
        ext_pin <= 1'b0;
        bus(OFS_IRQ_PENDING_CLR, 1'b1, 32'h0);
        bus(OFS_IRQ_PENDING_VIEW, 1'b0, ev_exp[k]);
        irq_is(|(ev_exp[k] & (en_exp | UNMASKABLE_BITS)));
        if (k == 2) `CHK("endpoint0_ready", 1'b1, ep0_ready)
        bus(OFS_IRQ_PENDING_CLR, 1'b1, ev_exp[k]);
        bus(OFS_IRQ_PENDING_VIEW, 1'b0, 32'h0);
        irq_is(1'b0);
      end
    end
    // Reset in mid-run with every enable set: the enables must fall back to their reset value.
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    en_exp = ENABLE_RESET;
    bus(OFS_IRQ_ENABLE_VIEW, 1'b0, ENABLE_RESET);
    `CHK("endpoint0_ready", 1'b0, ep0_ready)
    irq_is(1'b0);
    results();
  end
endmodule // usb_device_port_interrupt_regs_tb_top
bind usb_device_port_interrupt_regs usb_irq_checker #(.IDLE_CYCLES(IDLE_CYCLES)) u_chk (.clk_sys(clk_sys),
  .rst_n(rst_n), .address(address), .read(read), .readdata(readdata), .waitrequest(waitrequest),
  .setup_received_flag(setup_received_flag), .rx_bank0_full_flag(rx_bank0_full_flag),
  .rx_bank1_full_flag(rx_bank1_full_flag), .tx_complete_flag(tx_complete_flag),
  .stall_acknowledged_flag(stall_acknowledged_flag), .bus_activity(bus_activity),
  .bus_reset_active(bus_reset_active), .suspended(suspended), .endpoint0_ready(endpoint0_ready));
